// *** core/dpbr_consts.svh ***
// Constants for the diskette parameter block decoder and result builder.
// Assumes inclusion by bare name from core/ files.
`ifndef DPBR_CONSTS_SVH
`define DPBR_CONSTS_SVH
// ================================================================
// Port offsets
`define DPBR_PORT_PTR_LO     3'h1
`define DPBR_PORT_PTR_HI     3'h2
`define DPBR_PORT_RES_TYPE   3'h1
`define DPBR_PORT_RES_BYTE   3'h3
// ================================================================
// Parameter block layout
`define DPBR_BLOCK_LEN       3'h7
`define DPBR_CW_RANDOM_BIT   6
`define DPBR_CW_INT_HI       5
`define DPBR_CW_INT_LO       4
`define DPBR_CW_WLEN_BIT     3
`define DPBR_INT_ALL         2'h0
`define DPBR_INT_NONE        2'h1
`define DPBR_INT_ILLEGAL     2'h3
// ================================================================
// Limits
`define DPBR_TRACK_MAX       8'h4C
`define DPBR_SECTOR_MAX      8'h34
`define DPBR_SECTOR_MASK     8'h3F
// ================================================================
// Result bits
`define DPBR_RB_NOT_READY    7
`define DPBR_RB_WRITE_FAULT  6
`define DPBR_RB_WRITE_PROT   5
`define DPBR_RB_OVERRUN      4
`define DPBR_RB_ADDR         3
`define DPBR_RB_SEEK         2
`define DPBR_RB_CRC          1
`define DPBR_RB_DELETED      0
`define DPBR_RESULT_RESET    8'h00
`define DPBR_RES_TYPE_ERR    8'h00
// ================================================================
// Op codes (values arbitrary, encoding table unavailable)
`define DPBR_OP_RECAL        3'h0
`define DPBR_OP_SEEK         3'h1
`define DPBR_OP_FORMAT       3'h2
`define DPBR_OP_READ         3'h3
`define DPBR_OP_VERIFY       3'h4
`define DPBR_OP_WRITE        3'h5
`define DPBR_OP_WRITE_DEL    3'h6
`endif

// *** core/dpbr_pkg.sv ***
// Types for the diskette parameter block decoder.
// Assumes dpbr_consts.svh is available on the include path.
package dpbr_pkg;
  // ================================================================
  // Operation kinds
  typedef enum logic [2:0] {
    DPBR_RECAL, DPBR_SEEK, DPBR_FORMAT, DPBR_READ,
    DPBR_VERIFY, DPBR_WRITE, DPBR_WRITE_DEL, DPBR_BAD_OP
  } dpbr_op_t;

  // Decoded parameter block
  typedef struct packed {
    logic        random_fmt;
    logic [1:0]  int_ctl;
    logic        word_len;
    logic [1:0]  drive;
    dpbr_op_t    op;
    logic [7:0]  rec_count;
    logic [7:0]  track;
    logic [5:0]  sector;
    logic [15:0] buf_addr;
  } dpbr_params_t;

  // Event inputs from the operation sequencer and drive
  typedef struct packed {
    logic not_ready;
    logic write_fault;
    logic write_prot;
    logic overrun;
    logic seek_err;
    logic crc_err;
    logic deleted;
    logic id_crc;
    logic no_mark;
    logic data_mark;
  } dpbr_events_t;
endpackage : dpbr_pkg

// *** core/dpbr_top.sv ***
// Diskette parameter block fetcher, decoder and error result builder.
// Assumes a host port with decoded offsets, a byte memory read port with
// one-cycle-or-more latency answered by mem_rvalid, and an outside
// operation sequencer that reports events and completion on this clock.
// The drive ready pin is asynchronous; every other input is on clk.
// With ce low nothing moves, the ready synchroniser included, so a pin
// change made during a freeze is only seen once ce returns.
`include "dpbr_consts.svh"
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Seven-byte block fetched from memory at host pointer, fixed byte order.
// - Control bit 6 selects sequential or buffer-pattern sector numbering.
// - Control bits 5:4: 00 interrupts on completion/error, 01 none, 11 illegal.
// - Drive ready changes interrupt regardless of completion control.
// - Instruction bits 5:4 select drive 0 to 3.
// - Instruction bits 2:0 decode to one of seven operations.
// - Byte three is sector count; transfer stays within sectors 1-52.
// - Byte four is track number, valid 0 through 76.
// - Sector from byte five bits 5:0, valid 1-52, upper bits ignored.
// - Buffer address formed from bytes six low and seven high.
// - Result byte read after result type 00 drives error word.
// - Result bit 7: drive not ready before or during operation.
// - Result bit 6: write fault during a write.
// - Result bit 5: format or write to read-only diskette.
// - Result bit 4: drive byte request not serviced in time.
// - Result bit 3: track over 76, sector 0 or over 52, or overflow.
// - Result bit 2: head off expected track after movement.
// - Result bit 1: CRC mismatch on read or verify.
// - Result bit 0: deleted data mark on read or verify.
// - Compound codes: 3+1 ID CRC, 3+2+1 no mark, 3+2+1+0 data mark.
module dpbr_top
  import dpbr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  // Host port
  input  wire logic         io_wr,
  input  wire logic         io_rd,
  input  wire logic [2:0]   io_addr,
  input  wire logic [7:0]   io_wdata,
  output logic [7:0]        io_rdata,
  output logic              io_rvalid,
  // Memory fetch port
  output logic              mem_req,
  output logic [15:0]       mem_addr,
  input  wire logic         mem_rvalid,
  input  wire logic [7:0]   mem_rdata,
  // Operation sequencer side
  output dpbr_params_t      params,
  output logic              op_start,
  output logic              addr_err,
  input  wire logic         op_done,
  input  wire dpbr_events_t events,
  input  wire logic         drive_ready_pin,
  output logic              irq
);

  // ================================================================
  // Decode helpers
  // Code values come from the constants header; unknown codes become a bad op
  function automatic dpbr_op_t op_decode(input logic [2:0] code);
    dpbr_op_t o;
    o = DPBR_BAD_OP;
    case (code)
      `DPBR_OP_RECAL:     o = DPBR_RECAL;
      `DPBR_OP_SEEK:      o = DPBR_SEEK;
      `DPBR_OP_FORMAT:    o = DPBR_FORMAT;
      `DPBR_OP_READ:      o = DPBR_READ;
      `DPBR_OP_VERIFY:    o = DPBR_VERIFY;
      `DPBR_OP_WRITE:     o = DPBR_WRITE;
      `DPBR_OP_WRITE_DEL: o = DPBR_WRITE_DEL;
      default:            o = DPBR_BAD_OP;
    endcase
    return o;
  endfunction : op_decode

  // Address check; sum widened to 9 bits so a large count cannot wrap
  function automatic logic addr_bad(input logic [7:0] trk, input logic [5:0] sec,
                                    input logic [7:0] cnt);
    logic [8:0] sum;
    sum = {3'b000, sec} + {1'b0, cnt};
    return (trk > `DPBR_TRACK_MAX) || (sec == 6'h00)
           || ({2'b00, sec} > `DPBR_SECTOR_MAX)
           || (sum > {1'b0, `DPBR_SECTOR_MAX});
  endfunction : addr_bad

  // Operations that put data on the media
  function automatic logic is_write(input dpbr_op_t o);
    return (o == DPBR_FORMAT) || (o == DPBR_WRITE) || (o == DPBR_WRITE_DEL);
  endfunction : is_write

  // Operations that read the media and so can see CRC and deleted marks
  function automatic logic is_read(input dpbr_op_t o);
    return (o == DPBR_READ) || (o == DPBR_VERIFY);
  endfunction : is_read

  // ================================================================
  // Pin synchroniser for drive ready
  logic rdy_s1_r;
  logic rdy_s2_r;
  logic rdy_s3_r;

  // Reset to the ready level: a drive that is ready at release of reset
  // must not look like a ready change and raise a false interrupt
  always_ff @(posedge clk) begin
    if (srst) begin
      rdy_s1_r <= 1'b1;
      rdy_s2_r <= 1'b1;
      rdy_s3_r <= 1'b1;
    end else if (ce) begin
      rdy_s1_r <= drive_ready_pin;
      rdy_s2_r <= rdy_s1_r;
      rdy_s3_r <= rdy_s2_r;
    end
  end

  // ================================================================
  // Fetch state machine
  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_WAIT, ST_CHECK, ST_RUN
  } dpbr_state_t;

  dpbr_state_t  state_r;
  logic [7:0]   ptr_lo_r;
  logic [15:0]  ptr_r;
  logic [2:0]   idx_r;
  logic [7:0]   blk_r [0:6];
  logic [7:0]   result_r;
  logic         err_seen_r;

  // Start strobe; honoured only while idle
  wire logic host_start = io_wr && (io_addr == `DPBR_PORT_PTR_HI);

  // Address check, valid only in the check state; one copy keeps the
  // refusal, the result bit and the interrupt in step
  wire logic blk_bad = (state_r == ST_CHECK) && (params.op != DPBR_RECAL) &&
                       addr_bad(params.track, params.sector, params.rec_count);

  // Pointer low byte latch
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_lo_r <= 8'h00;
    end else if (ce && io_wr && (io_addr == `DPBR_PORT_PTR_LO)) begin
      ptr_lo_r <= io_wdata;
    end
  end

  // Sequencing of fetch, check and run; a start while busy is ignored
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r  <= ST_IDLE;
      ptr_r    <= 16'h0000;
      idx_r    <= 3'h0;
      mem_req  <= 1'b0;
      mem_addr <= 16'h0000;
      op_start <= 1'b0;
      addr_err <= 1'b0;
    end else if (ce) begin
      op_start <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (host_start) begin
            ptr_r    <= {io_wdata, ptr_lo_r};
            idx_r    <= 3'h0;
            addr_err <= 1'b0;
            state_r  <= ST_REQ;
          end
        end
        ST_REQ: begin
          // One request per byte; mem_addr holds until the next one
          mem_req  <= 1'b1;
          mem_addr <= ptr_r + {13'h0000, idx_r};
          state_r  <= ST_WAIT;
        end
        ST_WAIT: begin
          // Any latency is accepted; a late answer only stretches the fetch
          mem_req <= 1'b0;
          if (mem_rvalid) begin
            if (idx_r == `DPBR_BLOCK_LEN - 3'h1) begin
              state_r <= ST_CHECK;
            end else begin
              idx_r   <= idx_r + 3'h1;
              state_r <= ST_REQ;
            end
          end
        end
        ST_CHECK: begin
          // Checked before any head movement; a bad address never starts
          if (blk_bad) begin
            addr_err <= 1'b1;
            state_r  <= ST_IDLE;
          end else begin
            op_start <= 1'b1;
            state_r  <= ST_RUN;
          end
        end
        ST_RUN: begin
          // The outside sequencer owns the operation until it reports done
          if (op_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Block storage, indexed by fetch position
  // Flip-flops, not a memory: all seven bytes feed the decode at once
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 7; i++) begin
        blk_r[i] <= 8'h00;
      end
    end else if (ce && (state_r == ST_WAIT) && mem_rvalid) begin
      blk_r[idx_r] <= mem_rdata;
    end
  end

  // ================================================================
  // Decoded parameters, registered so outputs come from flip-flops
  // They trail the stored bytes by a cycle; the check state reads only
  // bytes that landed at least two cycles before it
  always_ff @(posedge clk) begin
    if (srst) begin
      params <= '0;
    end else if (ce) begin
      params.random_fmt <= blk_r[0][`DPBR_CW_RANDOM_BIT];
      params.int_ctl    <= blk_r[0][`DPBR_CW_INT_HI:`DPBR_CW_INT_LO];
      params.word_len   <= blk_r[0][`DPBR_CW_WLEN_BIT];
      params.drive      <= blk_r[1][5:4];
      params.op         <= op_decode(blk_r[1][2:0]);
      params.rec_count  <= blk_r[2];
      params.track      <= blk_r[3];
      params.sector     <= blk_r[4][5:0];
      params.buf_addr   <= {blk_r[6], blk_r[5]};
    end
  end

  // ================================================================
  // Result byte: sticky per operation, cleared by a new start
  // There is no other clear; a reading host sees the same byte each time
  always_ff @(posedge clk) begin
    if (srst) begin
      result_r <= `DPBR_RESULT_RESET;
    end else if (ce) begin
      if (state_r == ST_IDLE && host_start) begin
        result_r <= `DPBR_RESULT_RESET;
      end else begin
        if (blk_bad) begin
          result_r[`DPBR_RB_ADDR] <= 1'b1;
        end
        if (state_r == ST_RUN) begin
          if (events.not_ready || !rdy_s2_r) begin
            result_r[`DPBR_RB_NOT_READY] <= 1'b1;
          end
          if (events.write_fault && is_write(params.op)) begin
            result_r[`DPBR_RB_WRITE_FAULT] <= 1'b1;
          end
          if (events.write_prot && is_write(params.op)) begin
            result_r[`DPBR_RB_WRITE_PROT] <= 1'b1;
          end
          if (events.overrun) begin
            result_r[`DPBR_RB_OVERRUN] <= 1'b1;
          end
          if (events.seek_err) begin
            result_r[`DPBR_RB_SEEK] <= 1'b1;
          end
          if (events.crc_err && is_read(params.op)) begin
            result_r[`DPBR_RB_CRC] <= 1'b1;
          end
          if (events.deleted && is_read(params.op)) begin
            result_r[`DPBR_RB_DELETED] <= 1'b1;
          end
          // Compound codes overlay several bits at once
          if (events.id_crc) begin
            result_r[`DPBR_RB_ADDR] <= 1'b1;
            result_r[`DPBR_RB_CRC]  <= 1'b1;
          end
          if (events.no_mark || events.data_mark) begin
            result_r[`DPBR_RB_ADDR] <= 1'b1;
            result_r[`DPBR_RB_SEEK] <= 1'b1;
            result_r[`DPBR_RB_CRC]  <= 1'b1;
          end
          if (events.data_mark) begin
            result_r[`DPBR_RB_DELETED] <= 1'b1;
          end
        end
      end
    end
  end

  // ================================================================
  // Host reads: result type then result byte
  // Any other read returns zero so a stale result never leaks out
  always_ff @(posedge clk) begin
    if (srst) begin
      io_rdata  <= 8'h00;
      io_rvalid <= 1'b0;
    end else if (ce) begin
      io_rvalid <= io_rd;
      if (io_rd && io_addr == `DPBR_PORT_RES_BYTE) begin
        io_rdata <= result_r;
      end else if (io_rd && io_addr == `DPBR_PORT_RES_TYPE) begin
        io_rdata <= `DPBR_RES_TYPE_ERR;
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end

  // ================================================================
  // Address failure marker; delays the error interrupt by one cycle so
  // that it follows addr_err rather than racing it
  always_ff @(posedge clk) begin
    if (srst) begin
      err_seen_r <= 1'b0;
    end else if (ce) begin
      err_seen_r <= blk_bad;
    end
  end

  // Interrupt: completion gated by control bits, ready change always
  // Codes 10 and 11 give no completion interrupt; only 00 enables it
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= (rdy_s2_r != rdy_s3_r)
             || ((params.int_ctl == `DPBR_INT_ALL) &&
                 (((state_r == ST_RUN) && op_done) || err_seen_r));
    end
  end

endmodule : dpbr_top
`default_nettype wire

// *** verification/dpbr_mem_model.sv ***
// Memory partner: answers parameter block fetches after a chosen latency.
// Assumes the fetch port of dpbr_top on the same clock.
`timescale 1ns/1ns
`default_nettype none
module dpbr_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  input  wire logic [3:0]  lat,
  output logic             mem_rvalid,
  output logic [7:0]       mem_rdata
);
  logic [7:0]  mem [logic [15:0]];
  logic [15:0] a;
  // ================================================================
  // One fetch at a time; the data line shows the inverse once released
  initial begin
    mem_rvalid = 1'b0;
    mem_rdata  = 8'h00;
  end
  always begin
    @(posedge clk);
    #1;
    if (mem_req) begin
      a = mem_addr;
      @(posedge clk);
      repeat (lat) @(posedge clk);
      #1 mem_rvalid = 1'b1;
      mem_rdata = mem.exists(a) ? mem[a] : 8'h00;
      @(posedge clk);
      #1 mem_rvalid = 1'b0;
      mem_rdata = ~mem_rdata;
    end
  end
endmodule : dpbr_mem_model
`default_nettype wire

// *** verification/dpbr_top_asserts.sv ***
// Checker for dpbr_top: fetch order, decode, address check, results, irq.
// Assumes no start write while an operation runs; checks pause while ce is low.
`timescale 1ns/1ns
`default_nettype none
module dpbr_top_asserts
  import dpbr_pkg::*;
(
  input wire logic         clk,
  input wire logic         srst,
  input wire logic         ce,
  input wire logic         io_wr,
  input wire logic         io_rd,
  input wire logic [2:0]   io_addr,
  input wire logic [7:0]   io_wdata,
  input wire logic [7:0]   io_rdata,
  input wire logic         io_rvalid,
  input wire logic         mem_req,
  input wire logic [15:0]  mem_addr,
  input wire logic         mem_rvalid,
  input wire logic [7:0]   mem_rdata,
  input wire dpbr_params_t params,
  input wire logic         op_start,
  input wire logic         addr_err,
  input wire logic         op_done,
  input wire dpbr_events_t events,
  input wire logic         drive_ready_pin,
  input wire logic         irq
);
  logic [2:0]  rv_cnt_r;
  logic [3:0]  req_cnt_r;
  logic [7:0]  ptr_lo_r;
  logic [15:0] ptr_r;
  logic [15:0] last_addr_r;
  logic [7:0]  blk_r [7];
  logic [8:0]  span;
  logic        bad;
  // ================================================================
  // Shadow of the fetched block, restarted by each start write
  always_ff @(posedge clk) begin
    if (srst || (io_wr && io_addr == 3'h2)) begin
      rv_cnt_r  <= 3'h0;
      req_cnt_r <= 4'h0;
    end else begin
      if (mem_rvalid && rv_cnt_r != 3'h7) rv_cnt_r <= rv_cnt_r + 3'h1;
      if (mem_req) req_cnt_r <= req_cnt_r + 4'h1;
    end
  end
  // Data and pointer copies need no reset: only read after a fetch
  always_ff @(posedge clk) begin
    if (io_wr && io_addr == 3'h1) ptr_lo_r <= io_wdata;
    if (io_wr && io_addr == 3'h2) ptr_r <= {io_wdata, ptr_lo_r};
    if (mem_req) last_addr_r <= mem_addr;
    if (mem_rvalid && rv_cnt_r != 3'h7) blk_r[rv_cnt_r] <= mem_rdata;
  end
  // Sector plus count may pass the track end while both look sane
  assign span = {3'h0, blk_r[4][5:0]} + {1'h0, blk_r[2]};
  assign bad  = blk_r[1][2:0] != 3'h0 &&
                (blk_r[3] > 8'h4C || blk_r[4][5:0] == 6'h00 || span > 9'h034);
  // ================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);
  sequence s_byte_in; mem_rvalid && req_cnt_r < 4'h7; endsequence
  sequence s_checked; op_start || $rose(addr_err); endsequence
  property p_rtype; io_rd && io_addr == 3'h1 |=> io_rdata == 8'h00; endproperty
  a_rtype: assert property (p_rtype) else $error("result type not zero");
  property p_go; io_wr && io_addr == 3'h2 |-> ##2 mem_req && mem_addr == ptr_r; endproperty
  a_go: assert property (p_go) else $error("fetch not at pointer");
  property p_addr_seq;
    mem_req && req_cnt_r != 4'h0 |-> mem_addr == last_addr_r + 16'h0001 && req_cnt_r < 4'h7;
  endproperty
  a_addr_seq: assert property (p_addr_seq) else $error("fetch out of order");
  property p_next_req; s_byte_in |-> ##2 mem_req; endproperty
  a_next_req: assert property (p_next_req) else $error("next fetch late");
  property p_params;
    op_start |-> params.buf_addr == {blk_r[6], blk_r[5]} && params.track == blk_r[3] &&
                 params.rec_count == blk_r[2] && params.sector == blk_r[4][5:0];
  endproperty
  a_params: assert property (p_params) else $error("block fields wrong");
  property p_ctl;
    op_start |-> params.drive == blk_r[1][5:4] && 3'(params.op) == blk_r[1][2:0] &&
                 params.random_fmt == blk_r[0][6] && params.int_ctl == blk_r[0][5:4] &&
                 params.word_len == blk_r[0][3];
  endproperty
  a_ctl: assert property (p_ctl) else $error("control fields wrong");
  property p_check; s_checked |-> rv_cnt_r == 3'h7 && addr_err == bad && !op_start == bad;
  endproperty
  a_check: assert property (p_check) else $error("address check wrong");
  property p_irq_on; op_done && params.int_ctl == 2'h0 |=> irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("completion irq missing");
  property p_irq_off;
    op_done && params.int_ctl == 2'h1 && $stable(drive_ready_pin) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq not suppressed");
  property p_irq_err; $rose(addr_err) && params.int_ctl == 2'h0 |=> irq; endproperty
  a_irq_err: assert property (p_irq_err) else $error("error irq missing");
  property p_res_addr; io_rd && io_addr == 3'h3 && addr_err |=> io_rdata[3]; endproperty
  a_res_addr: assert property (p_res_addr) else $error("address bit missing");
endmodule : dpbr_top_asserts
bind dpbr_top dpbr_top_asserts chk (.clk, .srst, .ce, .io_wr, .io_rd, .io_addr, .io_wdata,
  .io_rdata, .io_rvalid, .mem_req, .mem_addr, .mem_rvalid, .mem_rdata, .params, .op_start,
  .addr_err, .op_done, .events, .drive_ready_pin, .irq);
`default_nettype wire

// *** verification/dpbr_top_tb_top.sv ***
// Testbench for dpbr_top: block fetch, address checks, result bits, irq.
// Assumes the memory model as fetch partner; ce drops only while the ports are quiet.
`timescale 1ns/1ns
`default_nettype none
module dpbr_top_tb_top;
  import dpbr_pkg::*;
  logic         clk, srst, ce, io_wr, io_rd, io_rvalid, mem_req, mem_rvalid;
  logic         op_start, addr_err, op_done, drive_ready_pin, irq;
  logic [2:0]   io_addr;
  logic [7:0]   io_wdata, io_rdata, mem_rdata;
  logic [15:0]  mem_addr;
  logic [3:0]   lat;
  dpbr_params_t params;
  dpbr_events_t events;
  logic [7:0]   exp_q [$];
  int           n_errors, cmp_count, cyc, i, k;
  // Rows {track, sector, count, result}; last row is a recalibrate
  logic [31:0]  addr_tab [8] = '{32'h4C34_0000, 32'h4D01_0108, 32'h0000_0108, 32'h0035_0008,
                               32'h1033_0208, 32'h1001_3300, 32'h10C1_0100, 32'h4D00_0000};
  // Rows {op code, result} for each sequencer event
  logic [15:0]  ev_tab [10] = '{16'h0080, 16'h0540, 16'h0220, 16'h0310, 16'h0104,
                              16'h0302, 16'h0401, 16'h060A, 16'h030E, 16'h040F};
  dpbr_top dut (.clk(clk), .srst(srst), .ce(ce), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .params(params), .op_start(op_start), .addr_err(addr_err), .op_done(op_done),
    .events(events), .drive_ready_pin(drive_ready_pin), .irq(irq));
  dpbr_mem_model mem_u (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr), .lat(lat),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  // ================================================================
  // Tasks
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // One-cycle strobe; held through the sampling edge
  task automatic io_op(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 io_wr = wr;
    io_rd = !wr;
    io_addr = a;
    io_wdata = d;
    @(posedge clk);
    #1 io_wr = 1'b0;
    io_rd = 1'b0;
  endtask : io_op
  task automatic io_rd_chk(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    io_op(1'b0, a, 8'h00);
  endtask : io_rd_chk
  // Bad blocks never start, so a bounded wait runs out and the result tells
  task automatic run_op(input logic [7:0] cw, input logic [7:0] ins, input logic [23:0] tsc,
                        input logic [9:0] ev, input logic [7:0] e);
    logic [15:0] p;
    p = 16'($urandom);
    mem_u.mem[p] = cw;
    mem_u.mem[p + 16'h0001] = ins;
    mem_u.mem[p + 16'h0002] = tsc[7:0];
    mem_u.mem[p + 16'h0003] = tsc[23:16];
    mem_u.mem[p + 16'h0004] = tsc[15:8];
    mem_u.mem[p + 16'h0005] = 8'($urandom);
    mem_u.mem[p + 16'h0006] = 8'($urandom);
    io_op(1'b1, 3'h1, p[7:0]);
    io_op(1'b1, 3'h2, p[15:8]);
    k = 0;
    while (op_start !== 1'b1 && k < 120) begin
      @(negedge clk);
      k++;
    end
    if (k < 120) begin
      @(posedge clk);
      #1 events = dpbr_events_t'(ev);
      @(posedge clk);
      #1 events = '0;
      op_done = 1'b1;
      @(posedge clk);
      #1 op_done = 1'b0;
    end
    io_rd_chk(3'h3, e);
  endtask : run_op
  // ================================================================
  // Clock, watchdog and result watcher
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      finish_test();
    end
  end
  always @(negedge clk) begin
    if (io_rvalid === 1'b1) chk(exp_q.pop_front(), io_rdata);
  end
  // ================================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 3'h0;
    io_wdata = 8'h00;
    op_done = 1'b0;
    events = '0;
    drive_ready_pin = 1'b1;
    lat = 4'h0;
    void'($urandom(32'h652d));
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    io_rd_chk(3'h1, 8'h00);
    io_rd_chk(3'h3, 8'h00);
    for (i = 0; i < 8; i++) begin
      lat = 4'(i);
      run_op({1'b0, i[0], 1'b0, i[1], 4'h0}, {2'h0, i[1:0], 1'b0, (i == 7) ? 3'h0 : 3'h3},
             addr_tab[i][31:8], 10'h000, addr_tab[i][7:0]);
    end
    for (i = 0; i < 10; i++) begin
      lat = 4'($urandom_range(3));
      run_op(8'h10, {2'h0, 2'(i), 1'b0, ev_tab[i][10:8]}, 24'h0203_01,
             10'h200 >> i, ev_tab[i][7:0]);
    end
    // Flags outside the operations that own them must stay clear
    run_op(8'h10, 8'h05, 24'h0203_01, 10'h010, 8'h00);
    run_op(8'h10, 8'h05, 24'h0203_01, 10'h008, 8'h00);
    run_op(8'h10, 8'h03, 24'h0203_01, 10'h100, 8'h00);
    run_op(8'h10, 8'h04, 24'h0203_01, 10'h080, 8'h00);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      #1 drive_ready_pin = i[0];
      k = 0;
      while (irq !== 1'b1 && k < 10) begin
        @(negedge clk);
        k++;
      end
      chk(8'h01, {7'h00, irq});
      repeat (4) @(posedge clk);
    end
    // Frozen clock enable: a ready change must wait for ce to return
    @(posedge clk);
    #1 ce = 1'b0;
    drive_ready_pin = 1'b0;
    k = 0;
    repeat (6) begin
      @(negedge clk);
      if (irq !== 1'b0) k++;
    end
    chk(8'h00, 8'(k));
    ce = 1'b1;
    k = 0;
    while (irq !== 1'b1 && k < 10) begin
      @(negedge clk);
      k++;
    end
    chk(8'h01, {7'h00, irq});
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : dpbr_top_tb_top
`default_nettype wire
